/* rtl/acc_comparator_control.sv */
// Analog comparator control and status with an APB register slave
//
// Design decision made here: the APB register port.
`include "acc_defines.svh"

module acc_comparator_control #(
	parameter int ADDR_W   = 6,
	parameter int SETTLE_W = 11
) (
	// APB clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB request
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	// APB answer
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	// Analog core
	input  wire logic              cmp_raw,
	output logic                   comp_enable,
	output logic                   low_power_select,
	output logic [1:0]             hysteresis_select,
	output logic [2:0]             pos_pin_select,
	output logic                   neg_pin_0_select,
	output logic                   neg_vref_select,
	output logic                   neg_conv_select,
	// Sleep controller
	input  wire logic              sleep_standby,
	input  wire logic              sleep_powerdown,
	input  wire logic              per_clk_active,
	// Event, pad and interrupt
	output logic                   event_out,
	output logic                   pad_out,
	output logic                   pad_oe_n,
	output logic                   irq
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [7:0]          control_reg;
	logic [7:0]          input_select_reg;
	logic                irq_enable_reg;
	logic                flag_reg;
	logic                state_reg;
	logic                comp_on_reg;
	logic [SETTLE_W-1:0] settle_reg;
	logic [SETTLE_W-1:0] settle_next;
	logic                settling;
	logic                comp_on;
	logic                cmp_out;
	logic                state_sync;
	logic                edge_hit;
	logic                wr_en;
	logic                rd_setup;
	logic                addr_ok;
	logic                flag_clear;
	logic [7:0]          rd_byte;
	acc_pkg::acc_edge_e  edge_mode;
	acc_pkg::acc_neg_e   neg_mode;

	assign edge_mode = acc_pkg::acc_edge_e'(control_reg[`ACC_CTL_EDGE_HI:`ACC_CTL_EDGE_LO]);
	assign neg_mode  = acc_pkg::acc_neg_e'(input_select_reg[`ACC_SEL_NEG_HI:`ACC_SEL_NEG_LO]);

	// ------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------

	// Zero-wait slave; unmapped addresses answer with an error
	always_comb begin
		unique case (paddr)
			ADDR_W'(`ACC_ADDR_CONTROL),
			ADDR_W'(`ACC_ADDR_INPUT_SELECT),
			ADDR_W'(`ACC_ADDR_IRQ_ENABLE),
			ADDR_W'(`ACC_ADDR_STATUS): addr_ok = 1'b1;
			default:                  addr_ok = 1'b0;
		endcase
	end

	assign pready     = 1'b1;
	assign pslverr    = psel & penable & ~addr_ok;
	assign wr_en      = psel & penable & pwrite & addr_ok;
	assign rd_setup   = psel & ~penable & ~pwrite;
	assign flag_clear = wr_en & (paddr == ADDR_W'(`ACC_ADDR_STATUS))
		& pwdata[`ACC_ST_FLAG];

	// ------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------

	// Control register: enable, hysteresis, low power, edge, pad, standby
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_reg <= `ACC_RST_CONTROL;
		end else if (wr_en && paddr == ADDR_W'(`ACC_ADDR_CONTROL)) begin
			control_reg <= pwdata[7:0];
		end
	end

	// Input select register; unused bits 6 and 2 never store
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_select_reg <= `ACC_RST_INPUT_SELECT;
		end else if (wr_en && paddr == ADDR_W'(`ACC_ADDR_INPUT_SELECT)) begin
			input_select_reg <= pwdata[7:0] & `ACC_SEL_WMASK;
		end
	end

	// Interrupt enable bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_enable_reg <= 1'b0;
		end else if (wr_en && paddr == ADDR_W'(`ACC_ADDR_IRQ_ENABLE)) begin
			irq_enable_reg <= pwdata[`ACC_IE_CMP];
		end
	end

	// ------------------------------------------------------------------
	// Analog core controls
	// ------------------------------------------------------------------

	// Powered when enabled, unless power-down or standby without run
	assign comp_on = control_reg[`ACC_CTL_ENABLE]
		& ~sleep_powerdown
		& (~sleep_standby | control_reg[`ACC_CTL_STBY_RUN]);

	assign comp_enable       = comp_on;
	assign low_power_select  = control_reg[`ACC_CTL_LOW_POWER];
	assign hysteresis_select = control_reg[`ACC_CTL_HYS_HI:`ACC_CTL_HYS_LO];

	// Positive pin one-hot; codes above two select nothing
	always_comb begin
		pos_pin_select = 3'h0;
		unique case (input_select_reg[`ACC_SEL_POS_HI:`ACC_SEL_POS_LO])
			3'h0:    pos_pin_select = 3'h1;
			3'h1:    pos_pin_select = 3'h2;
			3'h2:    pos_pin_select = 3'h4;
			default: pos_pin_select = 3'h0;
		endcase
	end

	// Negative source; the reserved code selects nothing
	always_comb begin
		neg_pin_0_select = 1'b0;
		neg_vref_select  = 1'b0;
		neg_conv_select  = 1'b0;
		unique case (neg_mode)
			acc_pkg::ACC_NEG_PIN0:     neg_pin_0_select = 1'b1;
			acc_pkg::ACC_NEG_RESERVED: neg_pin_0_select = 1'b0;
			acc_pkg::ACC_NEG_VREF:     neg_vref_select  = 1'b1;
			acc_pkg::ACC_NEG_CONV:     neg_conv_select  = 1'b1;
		endcase
	end

	// ------------------------------------------------------------------
	// Output path, unclocked toward event and pad
	// ------------------------------------------------------------------

	// Raw is high when positive exceeds negative; inversion before all uses
	assign cmp_out   = comp_on & (cmp_raw ^ input_select_reg[`ACC_SEL_INVERT]);
	assign event_out = cmp_out;
	assign pad_out   = cmp_out;
	assign pad_oe_n  = ~(comp_on & control_reg[`ACC_CTL_PAD_OE]);

	// ------------------------------------------------------------------
	// Start-up settling counter
	// ------------------------------------------------------------------

	// Remember the power state to see the turn-on moment
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comp_on_reg <= 1'b0;
		end else begin
			comp_on_reg <= comp_on;
		end
	end

	// Load the longer wait when the reference must also start
	always_comb begin
		settle_next = settle_reg;
		if (!comp_on) begin
			settle_next = '0;
		end else if (!comp_on_reg) begin
			if (neg_mode == acc_pkg::ACC_NEG_VREF) begin
				settle_next = SETTLE_W'(`ACC_VREF_CYC);
			end else begin
				settle_next = SETTLE_W'(`ACC_STARTUP_CYC);
			end
		end else if (settle_reg != '0) begin
			settle_next = settle_reg - SETTLE_W'(1);
		end
	end

	// Settling counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_reg <= '0;
		end else begin
			settle_reg <= settle_next;
		end
	end

	assign settling = (settle_reg != '0);

	// ------------------------------------------------------------------
	// Status path: synchroniser, state and edge detection
	// ------------------------------------------------------------------

	// Two flops bring the asynchronous output into the clock domain
	acc_sync #(
		.STAGES(`ACC_SYNC_STAGES)
	) u_state_sync (
		.clk  (pclk),
		.rst_n(presetn),
		.d    (cmp_out),
		.q    (state_sync)
	);

	// Third stage is the visible state; frozen without peripheral clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= 1'b0;
		end else if (per_clk_active) begin
			state_reg <= state_sync;
		end
	end

	// Edge match for the selected mode; reserved mode matches nothing
	always_comb begin
		edge_hit = 1'b0;
		unique case (edge_mode)
			acc_pkg::ACC_EDGE_ANY:      edge_hit = state_sync ^ state_reg;
			acc_pkg::ACC_EDGE_RESERVED: edge_hit = 1'b0;
			acc_pkg::ACC_EDGE_FALL:     edge_hit = ~state_sync & state_reg;
			acc_pkg::ACC_EDGE_RISE:     edge_hit = state_sync & ~state_reg;
		endcase
	end

	// Interrupt flag; a new edge wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_reg <= 1'b0;
		end else if (edge_hit && per_clk_active) begin
			flag_reg <= 1'b1;
		end else if (flag_clear) begin
			flag_reg <= 1'b0;
		end
	end

	// Request held while enabled and flagged
	assign irq = irq_enable_reg & flag_reg;

	// ------------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------------

	// Byte selected by the read address
	always_comb begin
		rd_byte = 8'h00;
		unique case (paddr)
			ADDR_W'(`ACC_ADDR_CONTROL):      rd_byte = control_reg;
			ADDR_W'(`ACC_ADDR_INPUT_SELECT): rd_byte = input_select_reg;
			ADDR_W'(`ACC_ADDR_IRQ_ENABLE):   rd_byte = {7'h00, irq_enable_reg};
			ADDR_W'(`ACC_ADDR_STATUS):       rd_byte = {3'h0, state_reg, 2'h0,
				settling, flag_reg};
			default:                         rd_byte = 8'h00;
		endcase
	end

	// Read data captured in the setup cycle, held through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata <= {24'h00_0000, rd_byte};
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_wr_sel;
		wr_en && paddr == ADDR_W'(`ACC_ADDR_INPUT_SELECT);
	endsequence
	sequence s_wr_ctl;
		wr_en && paddr == ADDR_W'(`ACC_ADDR_CONTROL);
	endsequence
	sequence s_rise_seen;
		per_clk_active && state_sync && !state_reg;
	endsequence
	sequence s_fall_seen;
		per_clk_active && !state_sync && state_reg;
	endsequence

	property p_pos_pin;
		s_wr_sel and (pwdata[5:3] == 3'h2) |=> pos_pin_select == 3'h4;
	endproperty
	a_pos_pin: assert property (p_pos_pin) else $error("positive select wrong");
	property p_neg_vref;
		s_wr_sel and (pwdata[1:0] == 2'h2) |=> neg_vref_select && !neg_pin_0_select;
	endproperty
	a_neg_vref: assert property (p_neg_vref) else $error("reference not selected");
	property p_neg_reserved;
		s_wr_sel and (pwdata[1:0] == 2'h1)
			|=> !neg_pin_0_select && !neg_vref_select && !neg_conv_select;
	endproperty
	a_neg_reserved: assert property (p_neg_reserved) else $error("reserved selects");
	property p_hyst;
		s_wr_ctl |=> hysteresis_select == $past(pwdata[2:1]);
	endproperty
	a_hyst: assert property (p_hyst) else $error("hysteresis not stored");
	property p_rise_flag;
		s_rise_seen and (edge_mode == acc_pkg::ACC_EDGE_RISE) |=> flag_reg;
	endproperty
	a_rise_flag: assert property (p_rise_flag) else $error("rise edge lost");
	property p_fall_ignored;
		s_fall_seen and (edge_mode == acc_pkg::ACC_EDGE_RISE) and !flag_reg
			|=> !flag_reg;
	endproperty
	a_fall_ignored: assert property (p_fall_ignored) else $error("falling set flag");

	property p_irq_hold;
		irq_enable_reg && flag_reg |-> irq ##1 (irq || !flag_reg || !irq_enable_reg);
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("request dropped");

	property p_clear;
		flag_reg && flag_clear && !(edge_hit && per_clk_active) |=> !flag_reg && !irq;
	endproperty
	a_clear: assert property (p_clear) else $error("flag not cleared");

	property p_state_lag;
		per_clk_active && $past(per_clk_active) |-> state_reg == $past(cmp_out, 3);
	endproperty
	a_state_lag: assert property (p_state_lag) else $error("state lag wrong");

	property p_powerdown;
		sleep_powerdown |-> !comp_enable && pad_oe_n && !event_out;
	endproperty
	a_powerdown: assert property (p_powerdown) else $error("power-down active");

	property p_standby;
		sleep_standby && !sleep_powerdown && control_reg[`ACC_CTL_ENABLE]
			|-> comp_enable == control_reg[`ACC_CTL_STBY_RUN];
	endproperty
	a_standby: assert property (p_standby) else $error("standby run wrong");

	property p_invert;
		comp_on |-> event_out == (cmp_raw ^ input_select_reg[`ACC_SEL_INVERT]);
	endproperty
	a_invert: assert property (p_invert) else $error("inversion wrong");

	property p_unused_bits;
		s_wr_sel |=> input_select_reg[6] == 1'b0 && input_select_reg[2] == 1'b0;
	endproperty
	a_unused_bits: assert property (p_unused_bits) else $error("unused bit stored");

	property p_settle;
		comp_on && !comp_on_reg |=> settling [*8];
	endproperty
	a_settle: assert property (p_settle) else $error("start-up wait missing");

endmodule : acc_comparator_control

/* rtl/acc_defines.svh */
// Register map, field positions, reset values and timing counts
//
// Contract
// - Positive code 0..2 picks positive pin 0..2
// - Negative codes: pin, reserved, reference, converter
// - Hysteresis codes: off, 10, 25, 50 mV
// - Edge codes: both, reserved, falling, rising
// - Matching output edge sets interrupt flag
// - Interrupt request while enable and flag set
// - Invert bit inverts output for every consumer
// - Pad enable drives comparator output to pin
// - Enable bit turns comparator on
// - Enabled output is unclocked event source
// - Low-power bit selects reduced-current mode
// - Idle sleep behaves exactly like active
// - Standby halts unless standby run bit set
// - Power-down disables comparator and pad output
// - Input select layout, unused bits zero, reset zero
// - Raw output high when positive exceeds negative
// - Interrupt enable bit 0 enables interrupt
// - Writing one to flag clears it
// - State bit lags output by three cycles
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------
`define ACC_IDX_CONTROL      4'h0
`define ACC_IDX_INPUT_SELECT 4'h2
`define ACC_IDX_IRQ_ENABLE   4'h6
`define ACC_IDX_STATUS       4'h7
`define ACC_ADDR_CONTROL      {`ACC_IDX_CONTROL, 2'b00}
`define ACC_ADDR_INPUT_SELECT {`ACC_IDX_INPUT_SELECT, 2'b00}
`define ACC_ADDR_IRQ_ENABLE   {`ACC_IDX_IRQ_ENABLE, 2'b00}
`define ACC_ADDR_STATUS       {`ACC_IDX_STATUS, 2'b00}

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ACC_CTL_ENABLE     0
`define ACC_CTL_HYS_LO     1
`define ACC_CTL_HYS_HI     2
`define ACC_CTL_LOW_POWER  3
`define ACC_CTL_EDGE_LO    4
`define ACC_CTL_EDGE_HI    5
`define ACC_CTL_PAD_OE     6
`define ACC_CTL_STBY_RUN   7
`define ACC_SEL_NEG_LO     0
`define ACC_SEL_NEG_HI     1
`define ACC_SEL_POS_LO     3
`define ACC_SEL_POS_HI     5
`define ACC_SEL_INVERT     7
`define ACC_SEL_WMASK      8'hbb
`define ACC_IE_CMP         0
`define ACC_ST_FLAG        0
`define ACC_ST_SETTLING    1
`define ACC_ST_STATE       4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ACC_RST_CONTROL      8'h00
`define ACC_RST_INPUT_SELECT 8'h00
`define ACC_RST_IRQ_ENABLE   8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define ACC_CLK_NS        50
`define ACC_STARTUP_NS    2500
`define ACC_VREF_NS       60000
`define ACC_STARTUP_CYC   ((`ACC_STARTUP_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`define ACC_VREF_CYC      ((`ACC_VREF_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`define ACC_SYNC_STAGES   2

`endif

/* rtl/acc_pkg.sv */
// Types shared by the comparator control block
package acc_pkg;

	// Edge modes for the interrupt condition
	typedef enum logic [1:0] {
		ACC_EDGE_ANY      = 2'b00,
		ACC_EDGE_RESERVED = 2'b01,
		ACC_EDGE_FALL     = 2'b10,
		ACC_EDGE_RISE     = 2'b11
	} acc_edge_e;

	// Negative input sources
	typedef enum logic [1:0] {
		ACC_NEG_PIN0     = 2'b00,
		ACC_NEG_RESERVED = 2'b01,
		ACC_NEG_VREF     = 2'b10,
		ACC_NEG_CONV     = 2'b11
	} acc_neg_e;

	// Hysteresis levels
	typedef enum logic [1:0] {
		ACC_HYS_OFF = 2'b00,
		ACC_HYS_10  = 2'b01,
		ACC_HYS_25  = 2'b10,
		ACC_HYS_50  = 2'b11
	} acc_hys_e;

endpackage : acc_pkg

/* rtl/acc_sync.sv */
// Multi-stage level synchroniser
module acc_sync #(
	parameter int STAGES = 2
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Level
	input  wire logic d,
	output logic      q
);

	logic [STAGES-1:0] chain_reg;

	// Shift chain; only the next stage reads each flop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chain_reg <= '0;
		end else begin
			chain_reg <= {chain_reg[STAGES-2:0], d};
		end
	end

	assign q = chain_reg[STAGES-1];

endmodule : acc_sync

/* sim/acc_analog_model.sv */
// Behavioural analog comparator core with its input sources
module acc_analog_model (
	// Clock
	input  wire logic       pclk,
	// Controls from the block
	input  wire logic       comp_enable,
	input  wire logic [2:0] pos_pin_select,
	input  wire logic       neg_pin_0_select,
	input  wire logic       neg_vref_select,
	input  wire logic       neg_conv_select,
	// Source voltages in millivolts
	input  wire integer     p0_mv,
	input  wire integer     p1_mv,
	input  wire integer     p2_mv,
	input  wire integer     n0_mv,
	input  wire integer     vr_mv,
	input  wire integer     cv_mv,
	// Raw output
	output logic            cmp_raw
);
	timeunit 1ns;
	timeprecision 1ps;

	int   vp;
	int   vn;
	logic sel_ok;
	logic idle_q = 1'b0;

	// An unpowered or unrouted core gives no stable level
	always_ff @(posedge pclk) begin
		idle_q <= ~idle_q;
	end

	// Route the selected sources to the two inputs
	always_comb begin
		vp = pos_pin_select[2] ? p2_mv : (pos_pin_select[1] ? p1_mv : p0_mv);
		vn = neg_vref_select ? vr_mv : (neg_conv_select ? cv_mv : n0_mv);
		sel_ok = (|pos_pin_select) && (neg_pin_0_select || neg_vref_select || neg_conv_select);
	end

	// When powered and routed, high only while the positive input is above the negative one
	assign cmp_raw = (comp_enable && sel_ok) ? (vp > vn) : idle_q;
endmodule : acc_analog_model

/* sim/test_analog_comparator_control.sv */
// Self-checking bench for the comparator control block
`include "acc_defines.svh"

module test_analog_comparator_control;
	timeunit 1ns;
	timeprecision 1ps;

	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [5:0] paddr = 6'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, cmp_raw, comp_enable, low_power_select, e;
	logic [1:0] hysteresis_select;
	logic [2:0] pos_pin_select;
	logic neg_pin_0_select, neg_vref_select, neg_conv_select;
	logic sleep_standby = 1'b0, sleep_powerdown = 1'b0, per_clk_active = 1'b1;
	logic event_out, pad_out, pad_oe_n, irq;
	int p0_mv = 300, p1_mv = 0, p2_mv = 0, n0_mv = 500, vr_mv = 0, cv_mv = 0;
	int n_mismatch = 0, checked = 0;

	acc_comparator_control dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .cmp_raw(cmp_raw), .comp_enable(comp_enable),
		.low_power_select(low_power_select), .hysteresis_select(hysteresis_select),
		.pos_pin_select(pos_pin_select), .neg_pin_0_select(neg_pin_0_select),
		.neg_vref_select(neg_vref_select), .neg_conv_select(neg_conv_select),
		.sleep_standby(sleep_standby), .sleep_powerdown(sleep_powerdown),
		.per_clk_active(per_clk_active), .event_out(event_out), .pad_out(pad_out),
		.pad_oe_n(pad_oe_n), .irq(irq));

	acc_analog_model model_u (.pclk(pclk), .comp_enable(comp_enable),
		.pos_pin_select(pos_pin_select), .neg_pin_0_select(neg_pin_0_select),
		.neg_vref_select(neg_vref_select), .neg_conv_select(neg_conv_select), .p0_mv(p0_mv),
		.p1_mv(p1_mv), .p2_mv(p2_mv), .n0_mv(n0_mv), .vr_mv(vr_mv), .cv_mv(cv_mv),
		.cmp_raw(cmp_raw));

	// ----------------------------------------------------------------------
	// Clock, compare and bus helpers
	// ----------------------------------------------------------------------
	always #25 pclk = ~pclk;

	task automatic end_sim;
		if (n_mismatch == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_sim

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		checked++;
		if (got !== ex) begin
			$display("unexpected %s expected %h seen %h", nm, ex, got);
			n_mismatch++;
		end
	endtask : chk

	// One APB transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic err);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		if (pready !== 1'b1) begin
			chk("pready", 1, 0);
			end_sim();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d}, r, e);
	endtask : wr

	// New positive level, then the interrupt follows on the third edge
	task automatic lag(input int v, input logic ex);
		p0_mv <= v;
		repeat (2) @(posedge pclk);
		#1 chk("irq early", 0, irq);
		@(posedge pclk);
		#1 chk("irq", ex, irq);
		@(posedge pclk);
	endtask : lag

	// ----------------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------------
	task automatic regs_and_mux;
		apb(1'b0, `ACC_ADDR_CONTROL, 0, r, e);
		chk("control", 0, r);
		apb(1'b0, `ACC_ADDR_INPUT_SELECT, 0, r, e);
		chk("input_select", 0, r);
		apb(1'b0, `ACC_ADDR_IRQ_ENABLE, 0, r, e);
		chk("irq_enable", 0, r);
		chk("pos select reset", 3'b001, pos_pin_select);
		wr(`ACC_ADDR_INPUT_SELECT, 8'hff);
		apb(1'b0, `ACC_ADDR_INPUT_SELECT, 0, r, e);
		chk("input_select mask", 8'hbb, r);
		apb(1'b0, 6'h04, 0, r, e);
		chk("unmapped err", 1, e);
		for (int c = 0; c < 8; c++) begin
			wr(`ACC_ADDR_INPUT_SELECT, 8'(c << 3));
			chk("pos select", (c < 3) ? (1 << c) : 0, pos_pin_select);
		end
		for (int c = 0; c < 4; c++) begin
			wr(`ACC_ADDR_INPUT_SELECT, 8'(c));
			chk("neg select", {c == 0, c == 2, c == 3},
				{neg_pin_0_select, neg_vref_select, neg_conv_select});
		end
		for (int h = 0; h < 4; h++) begin
			wr(`ACC_ADDR_CONTROL, 8'(h << 1));
			chk("hysteresis", h, hysteresis_select);
		end
		wr(`ACC_ADDR_CONTROL, 8'h08);
		chk("low power", 1, low_power_select);
	endtask : regs_and_mux

	task automatic enable_paths;
		p0_mv <= 700;
		wr(`ACC_ADDR_INPUT_SELECT, 8'h00);
		wr(`ACC_ADDR_CONTROL, 8'h41);
		apb(1'b0, `ACC_ADDR_STATUS, 0, r, e);
		chk("settling", 1, r[1]);
		repeat (50) @(posedge pclk);
		#1 chk("event", 1, event_out);
		chk("pad", 1, pad_out);
		chk("pad oe", 0, pad_oe_n);
		@(posedge pclk);
		wr(`ACC_ADDR_INPUT_SELECT, 8'h80);
		chk("event inv", 0, event_out);
		chk("pad inv", 0, pad_out);
		repeat (4) @(posedge pclk);
		apb(1'b0, `ACC_ADDR_STATUS, 0, r, e);
		chk("state inv", 0, r[4]);
		wr(`ACC_ADDR_INPUT_SELECT, 8'h00);
		wr(`ACC_ADDR_CONTROL, 8'h01);
		chk("pad off", 1, pad_oe_n);
		wr(`ACC_ADDR_CONTROL, 8'h00);
		chk("off", 0, {comp_enable, event_out});
	endtask : enable_paths

	task automatic edge_mode(input logic [1:0] m, input logic r_ex, input logic f_ex);
		wr(`ACC_ADDR_CONTROL, {2'b00, m, 4'h1});
		p0_mv <= 300;
		repeat (50) @(posedge pclk);
		wr(`ACC_ADDR_STATUS, 8'h01);
		lag(700, r_ex);
		wr(`ACC_ADDR_STATUS, 8'h01);
		lag(300, f_ex);
	endtask : edge_mode

	task automatic irq_mask;
		wr(`ACC_ADDR_IRQ_ENABLE, 8'h00);
		wr(`ACC_ADDR_STATUS, 8'h01);
		lag(700, 1'b0);
		apb(1'b0, `ACC_ADDR_STATUS, 0, r, e);
		chk("flag and state", 8'h11, r & 8'h13);
		wr(`ACC_ADDR_IRQ_ENABLE, 8'h01);
		chk("irq enabled", 1, irq);
		wr(`ACC_ADDR_STATUS, 8'h00);
		chk("irq write zero", 1, irq);
		wr(`ACC_ADDR_STATUS, 8'h01);
		chk("irq cleared", 0, irq);
	endtask : irq_mask

	task automatic sleep_modes;
		p0_mv <= 300;
		wr(`ACC_ADDR_CONTROL, 8'h01);
		sleep_standby <= 1'b1;
		@(posedge pclk);
		#1 chk("standby halt", 0, comp_enable);
		@(posedge pclk);
		wr(`ACC_ADDR_CONTROL, 8'h81);
		chk("standby run", 1, comp_enable);
		repeat (50) @(posedge pclk);
		wr(`ACC_ADDR_STATUS, 8'h01);
		per_clk_active <= 1'b0;
		p0_mv <= 700;
		repeat (6) @(posedge pclk);
		#1 chk("standby event", 1, event_out);
		chk("standby irq", 0, irq);
		@(posedge pclk);
		per_clk_active <= 1'b1;
		wr(`ACC_ADDR_CONTROL, 8'hc1);
		sleep_powerdown <= 1'b1;
		@(posedge pclk);
		#1 chk("powerdown", 2'b01, {comp_enable, pad_oe_n});
		@(posedge pclk);
		sleep_powerdown <= 1'b0;
		sleep_standby <= 1'b0;
		@(posedge pclk);
	endtask : sleep_modes

	// ----------------------------------------------------------------------
	// Main sequence and hang guard
	// ----------------------------------------------------------------------
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		regs_and_mux();
		enable_paths();
		wr(`ACC_ADDR_IRQ_ENABLE, 8'h01);
		edge_mode(2'h0, 1'b1, 1'b1);
		edge_mode(2'h1, 1'b0, 1'b0);
		edge_mode(2'h2, 1'b0, 1'b1);
		edge_mode(2'h3, 1'b1, 1'b0);
		irq_mask();
		sleep_modes();
		end_sim();
	end

	initial begin
		repeat (100000) @(posedge pclk);
		n_mismatch++;
		end_sim();
	end
endmodule : test_analog_comparator_control
